// [rtl/liutp_pkg.sv]
// Constants, types and register layout of the transmit pattern block.
//
// Operation
// - Select 00 passes normal rail data.
// - Mode bits choose DS3, E3 or STS-1.
// - Select 01 sends unframed all ones.
// - Select 01, DS3 with sonet bit: AIS.
// - Select 11 sends rate dependent PRBS.
// - Receive checker pattern follows line mode.
// - Pins 01: receive path, 16-bit buffer.
// - Pins 10: transmit path, 16-bit buffer.
// - Pins 11: transmit 32-bit; 00 disabled.
// - Select pair chooses the port's source.
package liutp_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register indices; the byte address is four times the index.
  localparam logic [5:0] IDX_CONFIG = 6'h00;
  localparam logic [5:0] IDX_TX_CFG = 6'h01;
  localparam logic [5:0] IDX_RX_CFG = 6'h02;
  localparam logic [5:0] IDX_STATUS = 6'h03;
  localparam logic [5:0] IDX_LATCHED = 6'h04;

  localparam int CFG_E3_BIT = 7;
  localparam int CFG_SONET_BIT = 6;
  localparam int CFG_SEL_A_BIT = 3;
  localparam int CFG_SEL_B_BIT = 2;
  localparam logic [7:0] CFG_WMASK = 8'hcc;
  localparam int TX_JA_BIT = 4;
  localparam int RX_JA_BIT = 4;
  localparam logic [7:0] JA_WMASK = 8'h10;
  localparam logic [7:0] CFG_RESET = 8'h00;

  localparam int ST_SYNC_BIT = 4;
  localparam int ST_JA_TX_BIT = 2;
  localparam int ST_JA_EN_BIT = 1;
  localparam int ST_JA_D32_BIT = 0;
  localparam int LAT_ERR_BIT = 3;

  // DS3 M-frame layout.
  localparam logic [6:0] AIS_BLOCK_LAST = 7'h54;
  localparam logic [2:0] AIS_BLKS_LAST = 3'h7;
  localparam logic [2:0] AIS_SUBS_LAST = 3'h6;
  localparam logic AIS_P_BIT = 1'b0;

  localparam logic [22:0] PRBS_SEED = 23'h7fffff;
  localparam int PRBS_SYNC_COUNT = 32;

  typedef enum logic [2:0] {
    SRC_NORMAL,
    SRC_ONES,
    SRC_AIS,
    SRC_MARK3,
    SRC_PRBS
  } liutp_src_t;

  typedef struct packed {
    logic pos;
    logic neg;
  } liutp_line_t;

  typedef struct packed {
    logic enable;
    logic tx_path;
    logic depth_32;
  } liutp_ja_t;

endpackage

// [rtl/liutp_top.sv]
// Transmit source selection, pattern generators, PRBS checker and jitter
// attenuator placement behind an APB register slave.
//
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module liutp_top #(
  parameter int SYNC_COUNT = liutp_pkg::PRBS_SYNC_COUNT
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [liutp_pkg::ADDR_W-1:0] paddr,
  input wire logic [liutp_pkg::DATA_W-1:0] pwdata,
  output logic [liutp_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hw_mode,
  input wire logic tx_jitter_atten_pin,
  input wire logic rx_jitter_atten_pin,
  input wire logic tx_positive_rail,
  input wire logic tx_negative_rail,
  input wire logic rx_prbs_data,
  input wire logic rx_prbs_valid,
  output liutp_pkg::liutp_line_t line_out,
  output liutp_pkg::liutp_ja_t ja_cfg,
  output logic prbs_sync
);

  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] tx_cfg;
    logic [7:0] rx_cfg;
    logic err_lat;
    logic [liutp_pkg::DATA_W-1:0] rdata;
    logic [1:0] mark_cnt;
    logic [6:0] ais_bit;
    logic [2:0] ais_blk;
    logic [2:0] ais_sub;
    logic [22:0] lfsr;
    logic [22:0] rx_sh;
    logic [5:0] match_cnt;
    logic sync;
    liutp_pkg::liutp_line_t line;
    liutp_pkg::liutp_ja_t ja;
  } liutp_state_t;

  liutp_state_t s_q;
  liutp_state_t s_d;

  logic [5:0] idx;
  logic hit;
  logic wr_en;
  logic rd_setup;
  logic e3_mode;
  logic sonet_mode;
  logic prbs_long;
  logic sel_a;
  logic sel_b;
  liutp_pkg::liutp_src_t src;
  logic ais_val;
  logic prbs_fb;
  logic rx_bit;
  logic rx_pred;
  logic gen_bit;
  logic tx_ja_sel;
  logic rx_ja_sel;
  logic err_event;

  assign idx = paddr[7:2];
  assign hit = (paddr[1:0] == 2'h0) && (idx <= liutp_pkg::IDX_LATCHED);
  assign wr_en = psel && penable && pwrite && hit;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata = s_q.rdata;
  assign line_out = s_q.line;
  assign ja_cfg = s_q.ja;
  assign prbs_sync = s_q.sync;

  assign e3_mode = s_q.cfg[liutp_pkg::CFG_E3_BIT];
  assign sonet_mode = s_q.cfg[liutp_pkg::CFG_SONET_BIT];
  assign sel_a = s_q.cfg[liutp_pkg::CFG_SEL_A_BIT];
  assign sel_b = s_q.cfg[liutp_pkg::CFG_SEL_B_BIT];
  // Only E3 uses the long sequence; DS3 and STS-1 share the short one.
  assign prbs_long = e3_mode && !sonet_mode;

  // The generated patterns assume the host keeps the mode steady while a
  // pattern is selected, so no resynchronisation on mode change is done.
  always_comb begin
    src = liutp_pkg::SRC_NORMAL;
    case ({sel_a, sel_b})
      2'b00: src = liutp_pkg::SRC_NORMAL;
      2'b01: begin
        if (!e3_mode && sonet_mode) begin
          src = liutp_pkg::SRC_AIS;
        end else begin
          src = liutp_pkg::SRC_ONES;
        end
      end
      2'b10: src = liutp_pkg::SRC_MARK3;
      2'b11: src = liutp_pkg::SRC_PRBS;
      default: src = liutp_pkg::SRC_NORMAL;
    endcase
  end

  // DS3 AIS: alarm payload 1010 with C-bits zero and valid framing bits.
  always_comb begin
    ais_val = 1'b0;
    if (s_q.ais_bit != 7'h00) begin
      ais_val = s_q.ais_bit[0];
    end else begin
      case (s_q.ais_blk)
        3'h0: begin
          case (s_q.ais_sub)
            3'h0: ais_val = 1'b1;
            3'h1: ais_val = 1'b1;
            3'h2: ais_val = liutp_pkg::AIS_P_BIT;
            3'h3: ais_val = liutp_pkg::AIS_P_BIT;
            3'h4: ais_val = 1'b0;
            3'h5: ais_val = 1'b1;
            default: ais_val = 1'b0;
          endcase
        end
        3'h1: ais_val = 1'b1;
        3'h7: ais_val = 1'b1;
        default: ais_val = 1'b0;
      endcase
    end
  end

  assign prbs_fb = prbs_long ? (s_q.lfsr[22] ^ s_q.lfsr[17])
                             : (s_q.lfsr[14] ^ s_q.lfsr[13]);
  assign rx_bit = !rx_prbs_data;
  assign rx_pred = prbs_long ? (s_q.rx_sh[22] ^ s_q.rx_sh[17])
                             : (s_q.rx_sh[14] ^ s_q.rx_sh[13]);

  always_comb begin
    gen_bit = 1'b0;
    case (src)
      liutp_pkg::SRC_ONES: gen_bit = 1'b1;
      liutp_pkg::SRC_AIS: gen_bit = ais_val;
      liutp_pkg::SRC_MARK3: gen_bit = (s_q.mark_cnt == 2'h0);
      liutp_pkg::SRC_PRBS: gen_bit = !prbs_fb;
      default: gen_bit = 1'b0;
    endcase
  end

  assign tx_ja_sel = hw_mode ? tx_jitter_atten_pin
                             : s_q.tx_cfg[liutp_pkg::TX_JA_BIT];
  assign rx_ja_sel = hw_mode ? rx_jitter_atten_pin
                             : s_q.rx_cfg[liutp_pkg::RX_JA_BIT];
  assign err_event = rx_prbs_valid && s_q.sync && (rx_bit != rx_pred);

  always_comb begin
    s_d = s_q;

    // Register writes take effect in the access phase.
    if (wr_en) begin
      case (idx)
        liutp_pkg::IDX_CONFIG:
          s_d.cfg = pwdata[7:0] & liutp_pkg::CFG_WMASK;
        liutp_pkg::IDX_TX_CFG:
          s_d.tx_cfg = pwdata[7:0] & liutp_pkg::JA_WMASK;
        liutp_pkg::IDX_RX_CFG:
          s_d.rx_cfg = pwdata[7:0] & liutp_pkg::JA_WMASK;
        liutp_pkg::IDX_LATCHED: begin
          if (pwdata[liutp_pkg::LAT_ERR_BIT]) begin
            s_d.err_lat = 1'b0;
          end
        end
        default: s_d.cfg = s_q.cfg;
      endcase
    end
    // A new error beats a clear in the same cycle.
    if (err_event) begin
      s_d.err_lat = 1'b1;
    end

    // Read data is captured in the setup phase for the access phase.
    // An unmapped read returns zero, whatever the index bits say.
    if (rd_setup && !hit) begin
      s_d.rdata = '0;
    end else if (rd_setup) begin
      s_d.rdata = '0;
      case (idx)
        liutp_pkg::IDX_CONFIG: s_d.rdata[7:0] = s_q.cfg;
        liutp_pkg::IDX_TX_CFG: s_d.rdata[7:0] = s_q.tx_cfg;
        liutp_pkg::IDX_RX_CFG: s_d.rdata[7:0] = s_q.rx_cfg;
        liutp_pkg::IDX_STATUS: begin
          s_d.rdata[liutp_pkg::ST_SYNC_BIT] = s_q.sync;
          s_d.rdata[liutp_pkg::ST_JA_TX_BIT] = s_q.ja.tx_path;
          s_d.rdata[liutp_pkg::ST_JA_EN_BIT] = s_q.ja.enable;
          s_d.rdata[liutp_pkg::ST_JA_D32_BIT] = s_q.ja.depth_32;
        end
        liutp_pkg::IDX_LATCHED:
          s_d.rdata[liutp_pkg::LAT_ERR_BIT] = s_q.err_lat;
        default: s_d.rdata = '0;
      endcase
    end

    // Pattern sequencers run freely so a selection starts at once.
    if (s_q.mark_cnt == 2'h2) begin
      s_d.mark_cnt = 2'h0;
    end else begin
      s_d.mark_cnt = s_q.mark_cnt + 2'h1;
    end

    if (s_q.ais_bit == liutp_pkg::AIS_BLOCK_LAST) begin
      s_d.ais_bit = 7'h00;
      if (s_q.ais_blk == liutp_pkg::AIS_BLKS_LAST) begin
        s_d.ais_blk = 3'h0;
        if (s_q.ais_sub == liutp_pkg::AIS_SUBS_LAST) begin
          s_d.ais_sub = 3'h0;
        end else begin
          s_d.ais_sub = s_q.ais_sub + 3'h1;
        end
      end else begin
        s_d.ais_blk = s_q.ais_blk + 3'h1;
      end
    end else begin
      s_d.ais_bit = s_q.ais_bit + 7'h01;
    end

    // A zero state would lock the generator up, so it is reseeded.
    if (s_q.lfsr == 23'h000000) begin
      s_d.lfsr = liutp_pkg::PRBS_SEED;
    end else begin
      s_d.lfsr = {s_q.lfsr[21:0], prbs_fb};
    end

    // Self-synchronising checker: it locks after a run of good bits.
    if (rx_prbs_valid) begin
      s_d.rx_sh = {s_q.rx_sh[21:0], rx_bit};
      if (rx_bit == rx_pred) begin
        if (s_q.match_cnt == 6'(SYNC_COUNT - 1)) begin
          s_d.sync = 1'b1;
        end else begin
          s_d.match_cnt = s_q.match_cnt + 6'h01;
        end
      end else begin
        s_d.match_cnt = 6'h00;
        s_d.sync = 1'b0;
      end
    end

    if (src == liutp_pkg::SRC_NORMAL) begin
      s_d.line.pos = tx_positive_rail;
      s_d.line.neg = tx_negative_rail;
    end else begin
      s_d.line.pos = gen_bit;
      s_d.line.neg = 1'b0;
    end

    s_d.ja.enable = tx_ja_sel || rx_ja_sel;
    s_d.ja.tx_path = tx_ja_sel;
    s_d.ja.depth_32 = tx_ja_sel && rx_ja_sel;
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
      s_q.cfg <= liutp_pkg::CFG_RESET;
      s_q.lfsr <= liutp_pkg::PRBS_SEED;
    end else begin
      s_q <= s_d;
    end
  end

endmodule
`default_nettype wire

// [testbench/liutp_sva.sv]
// Port checker of the transmit pattern block.
`timescale 1ns/1ps
`default_nettype none
module liutp_sva (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic hw_mode,
  input wire logic tx_jitter_atten_pin,
  input wire logic rx_jitter_atten_pin,
  input wire logic tx_positive_rail,
  input wire logic tx_negative_rail,
  input wire liutp_pkg::liutp_line_t line_out,
  input wire liutp_pkg::liutp_ja_t ja_cfg
);
  // Shadow of the configuration register, rebuilt from bus writes.
  logic [7:0] c_q;
  wire [1:0] j = {tx_jitter_atten_pin, rx_jitter_atten_pin};
  wire [1:0] sel = c_q[3:2];
  wire [1:0] md = c_q[7:6];
  always_ff @(posedge sys_clk or posedge reset)
    if (reset) c_q <= 8'h00;
    else if (psel && penable && pwrite && paddr == 8'h00)
      c_q <= pwdata[7:0] & 8'hcc;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  ja_map_a: assert property (hw_mode |=> ja_cfg ==
    {$past(j) != 2'h0, $past(j[1]), $past(j) == 2'h3}) else $error("ja");
  pass_rail_a: assert property (!reset && sel == 2'h0 |=> line_out ==
    $past({tx_positive_rail, tx_negative_rail})) else $error("rails");
  all_ones_a: assert property (sel == 2'h1 && md != 2'h1
    |=> line_out == 2'h2) else $error("ones");
  ais_zero_a: assert property ((sel == 2'h1 && md == 2'h1)[*4] |->
    !(line_out.pos && $past(line_out.pos) && $past(line_out.pos, 2)))
    else $error("ais");
  mark_three_a: assert property ((sel == 2'h2)[*5] |-> !line_out.neg &&
    $countones({line_out.pos, $past(line_out.pos), $past(line_out.pos, 2)})
    == 1) else $error("mark");
  prbs_neg_a: assert property (sel == 2'h3 |=> !line_out.neg)
    else $error("prbs neg");
  bus_err_a: assert property (psel && penable |-> pslverr ==
    (paddr[1:0] != 2'h0 || paddr[7:2] > 6'h04)) else $error("slverr");
  ready_hi_a: assert property (psel && penable |-> pready)
    else $error("ready");
endmodule
bind liutp_top liutp_sva u_liutp_sva (.sys_clk(sys_clk), .reset(reset),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .hw_mode(hw_mode),
  .tx_jitter_atten_pin(tx_jitter_atten_pin),
  .rx_jitter_atten_pin(rx_jitter_atten_pin),
  .tx_positive_rail(tx_positive_rail), .tx_negative_rail(tx_negative_rail),
  .line_out(line_out), .ja_cfg(ja_cfg));
`default_nettype wire

// [testbench/liutp_fmodel.sv]
// Framer stand-in that feeds changing data onto the transmit rails.
`timescale 1ns/1ps
`default_nettype none
module liutp_fmodel (
  input wire logic sys_clk,
  input wire logic reset,
  output logic pos,
  output logic neg
);
  logic [6:0] s_q;
  always_ff @(posedge sys_clk or posedge reset)
    if (reset) s_q <= 7'h01;
    else s_q <= {s_q[5:0], s_q[6] ^ s_q[5]};
  // The rails never mark together, as a bipolar coder would not.
  assign pos = s_q[0];
  assign neg = s_q[3] & ~s_q[0];
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
// Self-checking bench of the transmit pattern block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_fail++; \
  $display("BAD %0t %h %h", $time, (a), (e)); end end
module tb_top;
  logic sys_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, hw_mode = 1'b0, tx_pin = 1'b0, rx_pin = 1'b0;
  logic rxd = 1'b0, rxv = 1'b0, pready, pslverr, pos, neg, sync, err;
  logic x = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  liutp_pkg::liutp_line_t line_out;
  liutp_pkg::liutp_ja_t ja_cfg;
  logic b [0:9519];
  logic [2:0] st [4] = '{3'h0, 3'h2, 3'h6, 3'h7};
  int n_fail = 0, comparisons = 0, cyc = 0, k, n, t, l;
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc > 30000) begin
      n_fail++;
      stop_test;
    end
  end
  liutp_fmodel u_liutp_fmodel (.sys_clk(sys_clk), .reset(reset),
    .pos(pos), .neg(neg));
  liutp_top #(.SYNC_COUNT(16)) u_liutp_top (.sys_clk(sys_clk),
    .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hw_mode(hw_mode), .tx_jitter_atten_pin(tx_pin),
    .rx_jitter_atten_pin(rx_pin), .tx_positive_rail(pos),
    .tx_negative_rail(neg), .rx_prbs_data(rxd), .rx_prbs_valid(rxv),
    .line_out(line_out), .ja_cfg(ja_cfg), .prbs_sync(sync));
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge sys_clk) penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Captures the line and loops it back to the checker one cycle late.
  task automatic grab(input int m);
    repeat (4) @(posedge sys_clk);
    n = 0;
    k = 0;
    for (int i = 0; i < m; i++) begin
      @(posedge sys_clk) rxd <= x;
      @(negedge sys_clk) x = line_out.pos;
      b[i] = x;
      n += x;
      k += line_out.neg;
    end
  endtask
  task automatic replay;
    for (int i = 0; i < 201; i++) begin
      @(posedge sys_clk) rxd <= b[i];
    end
    @(negedge sys_clk);
  endtask
  task automatic stop_test;
    if (n_fail == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    xfer(1'b1, 8'h00, 8'hff);
    xfer(1'b0, 8'h00, 8'h00);
    `CHK(r, 32'hcc);
    xfer(1'b0, 8'h14, 8'h00);
    `CHK(err, 1'b1);
    xfer(1'b1, 8'h00, 8'hc0);
    rxv <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      xfer(1'b1, 8'h00, {m[1:0], 6'h00});
      for (int s = 1; s < 4; s++) begin
        xfer(1'b1, 8'h00, {m[1:0], 2'h0, s[1:0], 2'h0});
        grab(s == 1 && m == 1 ? 9520 : 201);
        `CHK(k, 0);
        if (s == 1 && m == 1) begin
          for (int i = 0; i < 4760; i++) `CHK(b[i + 4760], b[i]);
          `CHK(n > 0 && n < 9520, 1'b1);
        end else if (s == 1) begin
          `CHK(n, 201);
        end else if (s == 2) begin
          `CHK(n, 67);
        end else begin
          t = m == 2 ? 18 : 14;
          l = m == 2 ? 23 : 15;
          for (int i = 24; i < 201; i++)
            `CHK(b[i] ^ b[i - t] ^ b[i - l], 1'b1);
          `CHK(n > 0 && n < 201, 1'b1);
          `CHK(sync, 1'b1);
        end
        xfer(1'b1, 8'h00, {m[1:0], 6'h00});
      end
    end
    xfer(1'b0, 8'h10, 8'h00);
    `CHK(r[3], 1'b1);
    rxv <= 1'b0;
    xfer(1'b1, 8'h10, 8'h08);
    xfer(1'b0, 8'h10, 8'h00);
    `CHK(r[3], 1'b0);
    rxv <= 1'b1;
    xfer(1'b1, 8'h00, 8'h80);
    replay;
    `CHK(sync, 1'b0);
    xfer(1'b1, 8'h00, 8'h00);
    replay;
    `CHK(sync, 1'b1);
    hw_mode <= 1'b1;
    for (int j = 0; j < 4; j++) begin
      {tx_pin, rx_pin} <= j[1:0];
      xfer(1'b0, 8'h0c, 8'h00);
      `CHK(r[2:0], st[j]);
    end
    hw_mode <= 1'b0;
    xfer(1'b1, 8'h04, 8'h10);
    xfer(1'b1, 8'h08, 8'h10);
    xfer(1'b0, 8'h0c, 8'h00);
    `CHK(r[2:0], 3'h7);
    xfer(1'b1, 8'h08, 8'h00);
    xfer(1'b0, 8'h0c, 8'h00);
    `CHK(r[2:0], 3'h6);
    stop_test;
  end
endmodule
`default_nettype wire
